// File: logic/sram_pkg.sv
/*
 Constants, carrier structs and the state type of the split-port double-data-rate burst memory.
 Assumes one system clock that runs far faster than the input clock pair it samples.
*/
package sram_pkg;

    // ------------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------------
    localparam bit ORG_WIDE = 1'b1;
    localparam int WORD_W = ORG_WIDE ? 36 : 18;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 2;
    localparam int BURST_LEN = 4;
    localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Timing, counted in input clock edges (half cycles)
    // ------------------------------------------------------------------
    localparam int READ_LAT_PLL_RUN_X2 = 5;
    localparam int READ_LAT_PLL_OFF_X2 = 2;
    localparam int PIPE_DEPTH = READ_LAT_PLL_RUN_X2;

    // ------------------------------------------------------------------
    // Address slot encoding
    // ------------------------------------------------------------------
    localparam logic SLOT_READ = 1'b0;
    localparam logic SLOT_WRITE = 1'b1;

    typedef enum logic [0:0] {
        burst_idle = 1'b0,
        burst_busy = 1'b1
    } burst_state_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic k;
        logic k_n;
        logic pll_disable_n;
        logic read_sel_n;
        logic write_sel_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } pins_type;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } read_tag_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [IDX_W-1:0] idx;
        logic [WORD_W-1:0] data;
    } wr_port_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [IDX_W-1:0] idx;
    } rd_port_type;

    typedef struct packed {
        pins_type pin_a;
        pins_type pin_b;
        logic k_prev;
        logic kn_prev;
        logic slot;
        burst_state_type wr_state;
        logic [ADDR_W-1:0] wr_addr;
        logic [IDX_W-1:0] wr_idx;
        read_tag_type [PIPE_DEPTH-1:0] pipe;
        burst_state_type out_state;
        logic [ADDR_W-1:0] out_addr;
        logic [IDX_W-1:0] out_idx;
        logic [WORD_W-1:0] rdata;
        logic valid;
        logic echo;
        logic echo_n;
    } state_type;

    function automatic logic [ADDR_W+IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr,
                                                           input logic [IDX_W-1:0] idx);
        word_index = {addr, idx};
    endfunction : word_index

endpackage : sram_pkg

// File: logic/burst_ram_core.sv
/*
 Word array of the burst memory with one write port and one read port.
 Assumes both ports are driven from logic on sys_clk; the read is combinational.
*/
`timescale 1ns/1ns
module burst_ram_core
    import sram_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write side
    input wire wr_port_type wr_port,
    // Read side
    input wire rd_port_type rd_port,
    output logic [WORD_W-1:0] rd_data
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] mem [0:(2**(ADDR_W+IDX_W))-1];
    logic same_word;

    // Self-timed commit: one word per accepted edge, no strobe from outside
    always_ff @(posedge sys_clk) begin
        if (wr_port.we) begin
            mem[word_index(wr_port.addr, wr_port.idx)] <= wr_port.data;
        end
    end

    // ------------------------------------------------------------------
    // Read with forwarding
    // ------------------------------------------------------------------
    // A word landing in this very cycle is not yet in the array, so it is forwarded
    assign same_word = wr_port.we &&
        (word_index(wr_port.addr, wr_port.idx) == word_index(rd_port.addr, rd_port.idx));

    always_comb begin
        if (same_word) begin
            rd_data = wr_port.data;
        end else begin
            rd_data = mem[word_index(rd_port.addr, rd_port.idx)];
        end
    end

    chk_forward_newest: assert property (@(posedge sys_clk)
        same_word |-> rd_data == wr_port.data)
        else $error("read of a word being written did not return the new data");

    chk_commit_lands: assert property (@(posedge sys_clk)
        wr_port.we |=> mem[$past(word_index(wr_port.addr, wr_port.idx))] == $past(wr_port.data))
        else $error("a written word did not land in the array");

endmodule : burst_ram_core

// File: logic/split_port_ddr_burst_sram.sv
/*
 Split-port burst memory: shared address bus, separate read and write data ports, four-word bursts
 on both input clock rises, read valid flag and echo clock pair.
 Assumes k and k_n come from the controller outside the sys_clk domain and are slow enough
 (several sys_clk periods per half cycle) for two-flop sampling and edge detection.
*/
`timescale 1ns/1ns
module split_port_ddr_burst_sram
    import sram_pkg::*;
(
    // System
    input wire logic sys_clk,
    input wire logic rst,
    // Input clock pair and mode
    input wire logic k,
    input wire logic k_n,
    input wire logic pll_disable_n,
    // Address and port selects
    input wire logic [ADDR_W-1:0] addr,
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    // Write data port
    input wire logic [WORD_W-1:0] write_data,
    // Read data port
    output logic [WORD_W-1:0] read_data,
    output logic read_valid_flag,
    // Echo clocks
    output logic echo_clock,
    output logic echo_clock_n
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_type st_q;
    state_type st_d;
    pins_type pins_in;
    wr_port_type wr_port;
    rd_port_type rd_port;
    logic [WORD_W-1:0] core_rdata;
    logic k_rise;
    logic kn_rise;
    logic edge_any;
    logic launch;
    read_tag_type launch_tag;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Next word of a burst; wraps after the fourth, leaving an idle write at the first word
    function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx);
        next_idx = idx + 2'h1;
    endfunction : next_idx

    assign pins_in = '{
        k: k,
        k_n: k_n,
        pll_disable_n: pll_disable_n,
        read_sel_n: read_sel_n,
        write_sel_n: write_sel_n,
        addr: addr,
        wdata: write_data
    };

    // ------------------------------------------------------------------
    // Array
    // ------------------------------------------------------------------
    burst_ram_core u_core (
        .sys_clk(sys_clk),
        .wr_port(wr_port),
        .rd_port(rd_port),
        .rd_data(core_rdata)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        wr_port = '0;
        rd_port = '{addr: st_q.out_addr, idx: st_q.out_idx};
        launch = 1'b0;
        launch_tag = '0;

        // Two flops on every pin; only the second stage is ever looked at
        st_d.pin_a = pins_in;
        st_d.pin_b = st_q.pin_a;

        // Rising edges only; falls of either clock leave the bursts, the read pipe and the slot alone
        k_rise = st_q.pin_b.k && !st_q.k_prev;
        kn_rise = st_q.pin_b.k_n && !st_q.kn_prev;
        edge_any = k_rise || kn_rise;
        st_d.k_prev = st_q.pin_b.k;
        st_d.kn_prev = st_q.pin_b.k_n;

        // Echo pair follows the sampled inputs and stops only while rst holds it low
        st_d.echo = st_q.pin_b.k;
        st_d.echo_n = st_q.pin_b.k_n;

        // Latency point depends on the mode pin, read live
        if (st_q.pin_b.pll_disable_n) begin
            launch_tag = st_q.pipe[READ_LAT_PLL_RUN_X2-1];
        end else begin
            launch_tag = st_q.pipe[READ_LAT_PLL_OFF_X2-1];
        end

        if (edge_any) begin
            // ----------------------------------------------------------
            // Write port: capture on its slot, then three more edges
            // ----------------------------------------------------------
            if (k_rise && st_q.slot == SLOT_WRITE && !st_q.pin_b.write_sel_n) begin
                wr_port = '{we: 1'b1, addr: st_q.pin_b.addr, idx: IDX_FIRST, data: st_q.pin_b.wdata};
                st_d.wr_state = burst_busy;
                st_d.wr_addr = st_q.pin_b.addr;
                st_d.wr_idx = next_idx(IDX_FIRST);
            end else begin
                case (st_q.wr_state)
                    burst_busy: begin
                        wr_port = '{we: 1'b1, addr: st_q.wr_addr, idx: st_q.wr_idx, data: st_q.pin_b.wdata};
                        st_d.wr_idx = next_idx(st_q.wr_idx);
                        if (st_q.wr_idx == IDX_LAST) begin
                            st_d.wr_state = burst_idle;
                        end
                    end
                    default: begin
                        st_d.wr_state = burst_idle;
                    end
                endcase
            end

            // ----------------------------------------------------------
            // Read address pipe, one stage per input clock edge
            // ----------------------------------------------------------
            st_d.pipe[0] = '{
                valid: k_rise && st_q.slot == SLOT_READ && !st_q.pin_b.read_sel_n,
                addr: st_q.pin_b.addr
            };
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                st_d.pipe[i] = st_q.pipe[i-1];
            end

            // Slots alternate on every k rise, selected or not
            if (k_rise) begin
                st_d.slot = ~st_q.slot;
            end

            // ----------------------------------------------------------
            // Read output burst; runs beside the write side untouched
            // ----------------------------------------------------------
            launch = launch_tag.valid;
            if (launch) begin
                st_d.out_state = burst_busy;
                st_d.out_addr = launch_tag.addr;
                st_d.out_idx = IDX_FIRST;
                rd_port = '{addr: launch_tag.addr, idx: IDX_FIRST};
                st_d.rdata = core_rdata;
                st_d.valid = 1'b1;
            end else begin
                case (st_q.out_state)
                    burst_busy: begin
                        if (st_q.out_idx == IDX_LAST) begin
                            st_d.out_state = burst_idle;
                            st_d.valid = 1'b0;
                        end else begin
                            st_d.out_idx = next_idx(st_q.out_idx);
                            rd_port = '{addr: st_q.out_addr, idx: next_idx(st_q.out_idx)};
                            st_d.rdata = core_rdata;
                        end
                    end
                    default: begin
                        st_d.out_state = burst_idle;
                        st_d.valid = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    // Separate output port; no turnaround with the write data inputs
    assign read_data = st_q.rdata;
    assign read_valid_flag = st_q.valid;
    assign echo_clock = st_q.echo;
    assign echo_clock_n = st_q.echo_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_slot_alternates: assert property (
        k_rise |=> st_q.slot != $past(st_q.slot))
        else $error("address slot did not alternate on a k rise");

    chk_launch_pll_on: assert property (
        edge_any && st_q.pin_b.pll_disable_n && st_q.pipe[4].valid
        |=> read_valid_flag && st_q.out_idx == 2'h0 && st_q.out_addr == $past(st_q.pipe[4].addr))
        else $error("read burst did not start five edges after capture");

    chk_launch_pll_off: assert property (
        edge_any && !st_q.pin_b.pll_disable_n && st_q.pipe[1].valid
        |=> read_valid_flag && st_q.out_idx == 2'h0 && st_q.out_addr == $past(st_q.pipe[1].addr))
        else $error("read burst did not start two edges after capture");

    chk_valid_four_words: assert property (
        $fell(read_valid_flag) |-> $past(st_q.out_idx) == 2'h3)
        else $error("valid flag dropped before the fourth word");

    chk_echo_follows: assert property (
        1'b1 |=> echo_clock == $past(st_q.pin_b.k) && echo_clock_n == $past(st_q.pin_b.k_n))
        else $error("echo clocks do not follow the input clocks");

    chk_no_falling_act: assert property (
        !edge_any |=> $stable(read_data) && $stable(st_q.wr_idx) && $stable(st_q.slot))
        else $error("state moved without a rising input clock edge");

    chk_write_deselect: assert property (
        k_rise && st_q.slot == SLOT_WRITE && st_q.pin_b.write_sel_n && st_q.wr_state == burst_idle
        |-> !wr_port.we ##1 st_q.wr_state == burst_idle)
        else $error("deselected write port accepted its slot");

    chk_read_deselect: assert property (
        k_rise && st_q.slot == SLOT_READ && st_q.pin_b.read_sel_n |=> !st_q.pipe[0].valid)
        else $error("deselected read port accepted its slot");

    chk_write_each_edge: assert property (
        edge_any && st_q.wr_state == burst_busy |-> wr_port.we && wr_port.addr == st_q.wr_addr)
        else $error("write burst word was not committed on its edge");

    chk_read_not_stalled: assert property (
        edge_any && launch && wr_port.we |=> read_valid_flag && st_q.out_idx == 2'h0)
        else $error("concurrent write disturbed a read launch");

    chk_input_two_flops: assert property (
        1'b1 |=> st_q.pin_b == $past(st_q.pin_a) && st_q.pin_a == $past(pins_in))
        else $error("input sampling stages out of step");

    chk_write_on_edge: assert property (
        wr_port.we |-> edge_any)
        else $error("array written without a rising input clock edge");

    chk_write_from_pins: assert property (
        wr_port.we |-> wr_port.data == st_q.pin_b.wdata)
        else $error("write word did not come from the input register");

    chk_valid_on_launch: assert property (
        $rose(read_valid_flag) |-> $past(launch))
        else $error("valid flag rose without a read launch");

    chk_valid_drops: assert property (
        edge_any && !launch && st_q.out_state == burst_busy && st_q.out_idx == IDX_LAST |=> !read_valid_flag)
        else $error("valid flag stayed high after the fourth word");

    chk_burst_steps: assert property (
        edge_any && !launch && st_q.out_state == burst_busy && st_q.out_idx != IDX_LAST
        |=> st_q.out_idx == next_idx($past(st_q.out_idx)) && read_valid_flag)
        else $error("read burst did not step to its next word");

    chk_burst_address: assert property (
        edge_any && !launch |=> $stable(st_q.out_addr))
        else $error("read burst changed address between words");

    chk_write_ends: assert property (
        edge_any && st_q.wr_state == burst_busy && st_q.wr_idx == IDX_LAST && !k_rise
        |=> st_q.wr_state == burst_idle)
        else $error("write burst ran past its fourth word");

    chk_read_capture: assert property (
        k_rise && st_q.slot == SLOT_READ && !st_q.pin_b.read_sel_n
        |=> st_q.pipe[0].valid && st_q.pipe[0].addr == $past(st_q.pin_b.addr))
        else $error("selected read slot did not take its address");

    chk_write_capture: assert property (
        k_rise && st_q.slot == SLOT_WRITE && !st_q.pin_b.write_sel_n
        |-> wr_port.we && wr_port.idx == IDX_FIRST && wr_port.addr == st_q.pin_b.addr)
        else $error("selected write slot did not take its address");

    chk_kn_no_capture: assert property (
        kn_rise && !k_rise |=> !st_q.pipe[0].valid)
        else $error("an address was taken on a complementary clock rise");

    chk_pipe_shifts: assert property (
        edge_any |=> st_q.pipe[1] == $past(st_q.pipe[0]))
        else $error("read address pipe did not advance on an input clock edge");

endmodule : split_port_ddr_burst_sram

// File: testbench/mem_controller_model.sv
/*
 Memory controller model: makes the input clock pair, offers one read and one write slot per frame,
 and captures read words.
 Assumes the bench changes its command inputs at sys_clk falling edges, well away from a take.
*/
`timescale 1ns/1ns
module mem_controller_model
    import sram_pkg::*;
(
    // System
    input wire logic sys_clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic cmd_pll,
    input wire logic cmd_rd_en,
    input wire logic [ADDR_W-1:0] cmd_rd_addr,
    input wire logic cmd_wr_en,
    input wire logic [ADDR_W-1:0] cmd_wr_addr,
    input wire logic [WORD_W-1:0] cmd_wr_base,
    output logic cmd_taken,
    output logic [15:0] cmd_edge,
    // Memory pins
    output logic k,
    output logic k_n,
    output logic pll_disable_n,
    output logic [ADDR_W-1:0] addr,
    output logic read_sel_n,
    output logic write_sel_n,
    output logic [WORD_W-1:0] write_data,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic read_valid_flag,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    // Captured read words
    output logic rx_strobe,
    output logic [WORD_W-1:0] rx_word,
    output logic [15:0] rx_edge,
    output logic [15:0] echo_edges
);
    int cnt;
    int dly;
    logic per, wp_en, e_prev, en_prev;
    logic [15:0] k_edges, cur;
    logic [ADDR_W-1:0] wp_a;
    logic [WORD_W-1:0] wp_base, b_base;

    // ------------------------------------------------------------------
    // Clock pair, slots and write words
    // ------------------------------------------------------------------
    initial begin
        {k, k_n, read_sel_n, write_sel_n, addr, write_data, b_base} = '0;
        pll_disable_n = 1'b1;
    end
    always @(negedge sys_clk) begin
        cmd_taken <= !rst && cnt == 8 && per;
        if (rst) begin
            cnt <= 6;
            per <= 1'b1;
            // Both low, so the first edge seen after reset is a k rise
            k <= 1'b0;
            k_n <= 1'b0;
            k_edges <= 16'h0;
            read_sel_n <= 1'b1;
            write_sel_n <= 1'b1;
            pll_disable_n <= cmd_pll;
        end else begin
            cnt <= (cnt == 11) ? 0 : cnt + 1;
            if (cnt == 11 || cnt == 5) begin
                k <= (cnt == 11);
                k_n <= (cnt == 5);
                k_edges <= k_edges + 16'h1;
            end
            if (cnt == 11) begin
                per <= ~per;
            end
            // Lines not in use carry a changing pattern, never a stale value
            if (cnt == 2) begin
                addr <= ~addr;
                write_data <= b_base ^ WORD_W'(per ? 1 : 3);
            end
            if (cnt == 8 && per) begin
                cmd_edge <= k_edges;
                pll_disable_n <= cmd_pll;
                addr <= cmd_rd_addr;
                read_sel_n <= ~cmd_rd_en;
                write_sel_n <= 1'b1;
                {wp_en, wp_a, wp_base} <= {cmd_wr_en, cmd_wr_addr, cmd_wr_base};
                write_data <= b_base ^ WORD_W'(2);
            end
            if (cnt == 8 && !per) begin
                addr <= wp_a;
                write_sel_n <= ~wp_en;
                read_sel_n <= 1'b1;
                b_base <= wp_base;
                write_data <= wp_base;
            end
        end
    end

    // ------------------------------------------------------------------
    // Capture mid-word after each echo rise, qualified by the flag
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        rx_strobe <= !rst && dly == 1 && read_valid_flag;
        if (rst) begin
            {e_prev, en_prev, echo_edges} <= '0;
            dly <= 0;
        end else begin
            e_prev <= echo_clock;
            en_prev <= echo_clock_n;
            if ((echo_clock && !e_prev) || (echo_clock_n && !en_prev)) begin
                dly <= 3;
                cur <= echo_edges;
                echo_edges <= echo_edges + 16'h1;
            end else if (dly != 0) begin
                dly <= dly - 1;
            end
            if (dly == 1 && read_valid_flag) begin
                rx_word <= read_data;
                rx_edge <= cur;
            end
        end
    end
endmodule : mem_controller_model

// File: testbench/testbench.sv
/*
 Self-checking bench of the split-port burst memory: a table of frames, a second reset, echo count.
 Assumes the controller model owns every memory pin and makes k at 48 ns.
*/
`timescale 1ns/1ns
module testbench
    import sram_pkg::*;
;
    typedef struct packed {
        logic pll;
        logic rd_en;
        logic [ADDR_W-1:0] rd_a;
        logic wr_en;
        logic [ADDR_W-1:0] wr_a;
        logic [WORD_W-1:0] base;
    } row_type;

    logic sys_clk, rst, cmd_pll, cmd_rd_en, cmd_wr_en, cmd_taken, rx_strobe;
    logic k, k_n, pll_disable_n, read_sel_n, write_sel_n, read_valid_flag, echo_clock, echo_clock_n;
    logic [ADDR_W-1:0] cmd_rd_addr, cmd_wr_addr, addr;
    logic [WORD_W-1:0] cmd_wr_base, write_data, read_data, rx_word;
    logic [15:0] cmd_edge, rx_edge, echo_edges;
    logic [WORD_W-1:0] mem [0:(1 << (ADDR_W + IDX_W)) - 1];
    logic [WORD_W-1:0] exp_w [$];
    logic [15:0] exp_e [$];
    row_type rows [12];
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    split_port_ddr_burst_sram u_split_port_ddr_burst_sram (.sys_clk(sys_clk), .rst(rst), .k(k), .k_n(k_n),
        .pll_disable_n(pll_disable_n), .addr(addr), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
        .write_data(write_data), .read_data(read_data), .read_valid_flag(read_valid_flag),
        .echo_clock(echo_clock), .echo_clock_n(echo_clock_n));
    mem_controller_model u_mem_controller_model (.sys_clk(sys_clk), .rst(rst), .cmd_pll(cmd_pll),
        .cmd_rd_en(cmd_rd_en), .cmd_rd_addr(cmd_rd_addr), .cmd_wr_en(cmd_wr_en), .cmd_wr_addr(cmd_wr_addr),
        .cmd_wr_base(cmd_wr_base), .cmd_taken(cmd_taken), .cmd_edge(cmd_edge), .k(k), .k_n(k_n),
        .pll_disable_n(pll_disable_n), .addr(addr), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
        .write_data(write_data), .read_data(read_data), .read_valid_flag(read_valid_flag),
        .echo_clock(echo_clock), .echo_clock_n(echo_clock_n), .rx_strobe(rx_strobe), .rx_word(rx_word),
        .rx_edge(rx_edge), .echo_edges(echo_edges));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic compare(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want);
        num_checks++;
        if (got !== want) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : compare

    // One frame: read slot then write slot; a same-frame write is seen by its read
    task automatic run_row(input row_type r);
        int lat;
        cmd_pll <= r.pll;
        {cmd_rd_en, cmd_rd_addr, cmd_wr_en, cmd_wr_addr, cmd_wr_base} <= {r.rd_en, r.rd_a, r.wr_en, r.wr_a, r.base};
        do @(posedge sys_clk); while (cmd_taken !== 1'b1);
        @(negedge sys_clk);
        lat = r.pll ? READ_LAT_PLL_RUN_X2 : READ_LAT_PLL_OFF_X2;
        for (int i = 0; i < BURST_LEN && r.wr_en; i++) mem[{r.wr_a, IDX_W'(i)}] = r.base ^ WORD_W'(i);
        for (int i = 0; i < BURST_LEN && r.rd_en; i++) begin
            exp_w.push_back(mem[{r.rd_a, IDX_W'(i)}]);
            exp_e.push_back(16'(int'(cmd_edge) + lat + i));
        end
    endtask : run_row

    task automatic drain;
        logic [15:0] e0;
        cmd_rd_en <= 1'b0;
        cmd_wr_en <= 1'b0;
        for (int t = 0; t < 200 && exp_w.size() != 0; t++) @(negedge sys_clk);
        compare(WORD_W'(exp_w.size()), '0);
        e0 = echo_edges;
        repeat (120) @(negedge sys_clk);
        compare(WORD_W'(echo_edges - e0), WORD_W'(20));
    endtask : drain

    // ------------------------------------------------------------------
    // Clock, timeout and read word checks
    // ------------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            tally_and_finish();
        end
    end
    always @(negedge sys_clk) begin
        if (rx_strobe === 1'b1) begin
            if (exp_w.size() == 0) begin
                err_count++;
                $display("mismatch at %0t: got %h expected %h", $time, rx_word, 0);
            end else begin
                compare(rx_word, exp_w.pop_front());
                compare(WORD_W'(rx_edge), WORD_W'(exp_e.pop_front()));
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cmd_pll = 1'b1;
        {cmd_rd_en, cmd_rd_addr, cmd_wr_en, cmd_wr_addr, cmd_wr_base} = '0;
        // Idle rows round the mode change, since a switch mid-traffic may drop a launch
        rows = '{'{1'b1, 1'b1, 8'h10, 1'b1, 8'h10, 36'h1_0000_0000}, '{1'b1, 1'b1, 8'h10, 1'b1, 8'h11, 36'h2_2222_2220},
                 '{1'b1, 1'b1, 8'h11, 1'b0, 8'h10, 36'hf_ffff_fff0}, '{1'b1, 1'b1, 8'h10, 1'b0, 8'h00, 36'h0},
                 '{1'b1, 1'b0, 8'h11, 1'b0, 8'h11, 36'h7_7777_7770}, '{1'b1, 1'b0, 8'h00, 1'b0, 8'h00, 36'h0},
                 '{1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 36'h0}, '{1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 36'h0},
                 '{1'b0, 1'b1, 8'hff, 1'b1, 8'hff, 36'h3_3333_3330}, '{1'b0, 1'b1, 8'h10, 1'b1, 8'h00, 36'h4_4444_4440},
                 '{1'b0, 1'b1, 8'h00, 1'b0, 8'hff, 36'h5_0000_0000}, '{1'b0, 1'b0, 8'h00, 1'b0, 8'h00, 36'h0}};
        repeat (6) @(negedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        foreach (rows[n]) run_row(rows[n]);
        drain();
        rst <= 1'b1;
        repeat (2) @(negedge sys_clk);
        compare(read_data, '0);
        compare(WORD_W'({read_valid_flag, echo_clock, echo_clock_n}), '0);
        repeat (4) @(negedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        run_row('{1'b0, 1'b1, 8'h22, 1'b1, 8'h22, 36'h6_0000_0000});
        drain();
        tally_and_finish();
    end
endmodule : testbench
